// ---- design/dcic_pkg.sv ----
// constants shared by the converter-control block: offsets, fields, resets
// assumes a 32-bit axi4-lite register bus and one clock domain
package dcic_pkg;
    localparam int NUM_INST = 2;
    localparam logic [35:0] BASE_CONV0 = 36'hffffa8000;
    localparam logic [35:0] BASE_CONV1 = 36'hffffac000;
    // the two windows differ in one address bit
    localparam int INST_SEL_BIT = 14;
    localparam int DATA_W = 10;
    localparam int NUM_TRIG = 6;
    localparam int SYNC_STAGES = 2;

    localparam logic [5:0] OFF_CONTROL = 6'h00;
    localparam logic [5:0] OFF_MODE = 6'h04;
    localparam logic [5:0] OFF_HOLDING = 6'h08;
    localparam logic [5:0] OFF_OUTPUT = 6'h0c;
    localparam logic [5:0] OFF_STATUS = 6'h10;
    localparam logic [5:0] OFF_IRQ_ENABLE = 6'h14;
    localparam logic [5:0] OFF_IRQ_DISABLE = 6'h18;
    localparam logic [5:0] OFF_IRQ_MASK = 6'h1c;
    localparam logic [5:0] OFF_EVT_STATUS = 6'h20;
    localparam logic [5:0] OFF_EVT_CLEAR = 6'h24;
    localparam logic [5:0] OFF_EVT_ENABLE = 6'h28;

    localparam int SOFT_RESET_BIT = 0;
    localparam int TRIG_EN_BIT = 0;
    localparam int TRIG_SEL_LSB = 1;
    localparam int TRIG_SEL_W = 3;
    localparam int RES_BIT = 4;
    localparam int MODE_W = 5;
    localparam int READY_BIT = 0;
    localparam int EVT_COPY_BIT = 0;

    localparam logic [4:0] MODE_RST = 5'h00;
    localparam logic [9:0] DATA_RST = 10'h000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : dcic_pkg

// ---- design/dcic_top.sv ----
// converter-control block: two register windows on one axi4-lite slave
// assumes timer outputs arrive asynchronous to aclk; 32-bit data bus
//
// Notes on behaviour
// - two instances, each with own window
// - control bit 0 one triggers soft reset
// - trigger off: copy one cycle after write
// - trigger on: copy only on timer event
// - select 0-5 picks timer, 6-7 none
// - 8-bit mode shifts written data left two
// - holding reads shifted value, upper bits zero
// - output register reads converted value, right-aligned
// - ready set after timer copy, cleared by write
// - ready zero when trigger off; enabling sets it
// - enable register bit 0 sets mask
// - disable register bit 0 clears mask
// - mask register reads mask, resets zero
// - each selected rising edge copies holding while trigger on
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module dcic_top #(
    parameter int ADDR_W = 16,
    parameter int NUM_INST = dcic_pkg::NUM_INST
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [dcic_pkg::NUM_TRIG-1:0] timer_out_a,
    output logic [NUM_INST*dcic_pkg::DATA_W-1:0] conv_out_data,
    output logic conv_irq
);
    generate
        if (NUM_INST < 1 || NUM_INST > 2 || ADDR_W <= dcic_pkg::INST_SEL_BIT)
        begin : g_bad_param
            $error("dcic_top: unsupported NUM_INST or ADDR_W");
        end
    endgenerate

    localparam logic [ADDR_W-1:0] USED_MASK =
        ADDR_W'(6'h3f) | (ADDR_W'(1) << dcic_pkg::INST_SEL_BIT);

    // shared by the read and write paths
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        logic [5:0] off;
        off = a[5:0];
        addr_ok = ((a & ~USED_MASK) == '0) && (off[1:0] == 2'b00)
            && (off <= dcic_pkg::OFF_EVT_ENABLE)
            && (int'(a[dcic_pkg::INST_SEL_BIT]) < NUM_INST);
    endfunction : addr_ok

    // ---------------- write channel ----------------
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire [ADDR_W-1:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr;
    wire [31:0] wr_data = w_take ? s_axi_wdata : w_data;
    wire [3:0] wr_strb = w_take ? s_axi_wstrb : w_strb;
    wire wr_fire = (aw_held || aw_take) && (w_held || w_take);
    wire wr_map = addr_ok(wr_addr);
    // a write with no byte lane set is answered but changes nothing
    wire wr_ok = wr_fire && wr_map && (wr_strb != 4'h0);
    wire [5:0] wr_off = wr_addr[5:0];
    wire wr_sel = wr_addr[dcic_pkg::INST_SEL_BIT];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= dcic_pkg::RESP_OKAY;
        end
        else
        begin
            aw_held <= !wr_fire && (aw_held || aw_take);
            w_held <= !wr_fire && (w_held || w_take);
            if (aw_take)
                aw_addr <= s_axi_awaddr;
            if (w_take)
            begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? dcic_pkg::RESP_OKAY
                                      : dcic_pkg::RESP_DECERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ---------------- timer trigger inputs ----------------
    logic [dcic_pkg::NUM_TRIG-1:0] trig_s1;
    logic [dcic_pkg::NUM_TRIG-1:0] trig_s2;
    logic [dcic_pkg::NUM_TRIG-1:0] trig_prev;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            trig_s1 <= '0;
            trig_s2 <= '0;
            trig_prev <= '0;
        end
        else
        begin
            trig_s1 <= timer_out_a;
            trig_s2 <= trig_s1;
            trig_prev <= trig_s2;
        end
    end

    // codes 6 and 7 land on the zero padding and never fire
    wire [7:0] trig_rise = 8'({2'b00, trig_s2 & ~trig_prev});

    // ---------------- per-instance converter control ----------------
    wire [31:0] rd_word [NUM_INST];
    wire [NUM_INST-1:0] irq_v;
    wire [5:0] rd_off = s_axi_araddr[5:0];

    genvar g;
    generate
        for (g = 0; g < NUM_INST; g++)
        begin : g_inst
            logic [dcic_pkg::MODE_W-1:0] mode;
            logic [dcic_pkg::DATA_W-1:0] hold;
            logic [dcic_pkg::DATA_W-1:0] outd;
            logic ready;
            logic mask;
            logic copy_pend;
            logic evt_sts;
            logic evt_en;

            wire here = wr_ok && (wr_sel == 1'(g));
            wire soft_rst = here && (wr_off == dcic_pkg::OFF_CONTROL)
                && wr_data[dcic_pkg::SOFT_RESET_BIT];
            wire mode_wr = here && (wr_off == dcic_pkg::OFF_MODE);
            wire hold_wr = here && (wr_off == dcic_pkg::OFF_HOLDING);
            wire ier_wr = here && (wr_off == dcic_pkg::OFF_IRQ_ENABLE);
            wire idr_wr = here && (wr_off == dcic_pkg::OFF_IRQ_DISABLE);
            wire ecl_wr = here && (wr_off == dcic_pkg::OFF_EVT_CLEAR);
            wire een_wr = here && (wr_off == dcic_pkg::OFF_EVT_ENABLE);
            wire trig_en = mode[dcic_pkg::TRIG_EN_BIT];
            wire new_en = wr_data[dcic_pkg::TRIG_EN_BIT];
            wire [2:0] tsel =
                mode[dcic_pkg::TRIG_SEL_LSB +: dcic_pkg::TRIG_SEL_W];
            wire trig_hit = trig_en && trig_rise[tsel];
            wire copy = copy_pend || trig_hit;
            // data arrives right-aligned; 8-bit mode moves it to the top
            wire [dcic_pkg::DATA_W-1:0] hold_in =
                mode[dcic_pkg::RES_BIT] ? {wr_data[7:0], 2'b00}
                                        : wr_data[dcic_pkg::DATA_W-1:0];

            always_ff @(posedge aclk)
            begin
                if (!aresetn || soft_rst)
                begin
                    mode <= dcic_pkg::MODE_RST;
                    hold <= dcic_pkg::DATA_RST;
                    outd <= dcic_pkg::DATA_RST;
                    ready <= 1'b0;
                    mask <= 1'b0;
                    copy_pend <= 1'b0;
                end
                else
                begin
                    if (mode_wr)
                        mode <= wr_data[dcic_pkg::MODE_W-1:0];
                    if (hold_wr)
                        hold <= hold_in;
                    copy_pend <= hold_wr && !trig_en;
                    // a copy takes the value held before a same-cycle write
                    if (copy)
                        outd <= hold;
                    if (!trig_en)
                        ready <= mode_wr && new_en;
                    else if (mode_wr && !new_en)
                        ready <= 1'b0;
                    else if (hold_wr)
                        ready <= 1'b0;
                    else if (trig_hit)
                        ready <= 1'b1;
                    if (ier_wr && wr_data[dcic_pkg::READY_BIT])
                        mask <= 1'b1;
                    else if (idr_wr && wr_data[dcic_pkg::READY_BIT])
                        mask <= 1'b0;
                end
            end

            // copy events are sticky; a new event beats a clear
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    evt_sts <= 1'b0;
                    evt_en <= 1'b0;
                end
                else
                begin
                    evt_sts <= (evt_sts && !(ecl_wr
                        && wr_data[dcic_pkg::EVT_COPY_BIT])) || copy;
                    if (een_wr)
                        evt_en <= wr_data[dcic_pkg::EVT_COPY_BIT];
                end
            end

            assign irq_v[g] = (ready && mask) || (evt_sts && evt_en);
            assign conv_out_data[g*dcic_pkg::DATA_W +: dcic_pkg::DATA_W] =
                outd;
            // write-only offsets fall through to zero on a read
            wire rd_mode = (rd_off == dcic_pkg::OFF_MODE);
            wire rd_hold = (rd_off == dcic_pkg::OFF_HOLDING);
            wire rd_outd = (rd_off == dcic_pkg::OFF_OUTPUT);
            wire rd_sts = (rd_off == dcic_pkg::OFF_STATUS);
            wire rd_mask = (rd_off == dcic_pkg::OFF_IRQ_MASK);
            wire rd_evs = (rd_off == dcic_pkg::OFF_EVT_STATUS);
            wire rd_eve = (rd_off == dcic_pkg::OFF_EVT_ENABLE);
            assign rd_word[g] =
                rd_mode ? 32'(mode) :
                rd_hold ? 32'(hold) :
                rd_outd ? 32'(outd) :
                rd_sts ? 32'(ready) :
                rd_mask ? 32'(mask) :
                rd_evs ? 32'(evt_sts) :
                rd_eve ? 32'(evt_en) :
                32'h0;
        end
    endgenerate

    assign conv_irq = |irq_v;

    // ---------------- read channel ----------------
    assign s_axi_arready = !s_axi_rvalid;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire rd_map = addr_ok(s_axi_araddr);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= dcic_pkg::RESP_OKAY;
        end
        else if (ar_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_map
                ? rd_word[s_axi_araddr[dcic_pkg::INST_SEL_BIT]] : 32'h0;
            s_axi_rresp <= rd_map ? dcic_pkg::RESP_OKAY
                                  : dcic_pkg::RESP_DECERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule : dcic_top

// ---- test/dcic_timer_model.sv ----
// behavioural timer channels that feed the trigger inputs
// assumes the bench asks for a pulse with fire for one cycle
`timescale 1ns/1ps
module dcic_timer_model (
    input wire logic aclk,
    input wire logic fire,
    input wire logic [5:0] which,
    output logic [5:0] timer_out_a
);
    initial timer_out_a = 6'h00;
    // waveform-mode output: clean high pulse, launched off the clock edge
    always @(posedge aclk)
    begin
        if (fire)
        begin
            #1 timer_out_a = which;
            repeat (4) @(posedge aclk);
            #1 timer_out_a = 6'h00;
        end
    end
endmodule : dcic_timer_model

// ---- test/dcic_monitor.sv ----
// bus handshake and output checks on the converter-control block
// assumes one aclk domain with synchronous active-low reset
`timescale 1ns/1ps
module dcic_monitor #(
    parameter int ADDR_W = 16,
    parameter int NUM_INST = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_INST*dcic_pkg::DATA_W-1:0] conv_out_data,
    input wire logic conv_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_write_refused:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel ready while response pending");
    chk_read_refused:
        assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready while data pending");
    chk_resp_stands:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before accepted");
    chk_rdata_stands:
        assert property (s_axi_rvalid && !s_axi_rready |=>
            s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before accepted");
    chk_read_latency:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_write_latency:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
            s_axi_wready |=> s_axi_bvalid)
        else $error("write answer late");
    chk_read_unmapped:
        assert property (s_axi_arvalid && s_axi_arready &&
            s_axi_araddr[13:6] != 8'h00 |=> s_axi_rresp == 2'h3 &&
            s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    chk_write_unmapped:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
            s_axi_wready && s_axi_awaddr[13:6] != 8'h00 |=> s_axi_bresp == 2'h3)
        else $error("unmapped write not refused");
    chk_reset_quiet:
        assert property ($rose(aresetn) |-> conv_irq == 1'b0 &&
            conv_out_data == '0 ##1 conv_irq == 1'b0)
        else $error("outputs not cleared by reset");
endmodule : dcic_monitor

bind dcic_top dcic_monitor #(.ADDR_W(ADDR_W), .NUM_INST(NUM_INST)) u_mon (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .conv_out_data, .conv_irq
);

// ---- test/dac_control_interface_test.sv ----
// register-level tests of the converter-control block over axi4-lite
// assumes instance 1 answers 0x4000 above instance 0
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module dac_control_interface_test;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, fire;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, conv_irq;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] timer_out_a, which;
    logic [19:0] conv_out_data;
    logic [5:0] regs [5] = '{dcic_pkg::OFF_MODE, dcic_pkg::OFF_HOLDING,
        dcic_pkg::OFF_OUTPUT, dcic_pkg::OFF_STATUS, dcic_pkg::OFF_IRQ_MASK};
    logic [9:0] last;
    int fail_count, n_tests;
    localparam logic [1:0] OK = dcic_pkg::RESP_OKAY;
    localparam logic [1:0] DE = dcic_pkg::RESP_DECERR;
    dcic_top dut (.*);
    dcic_timer_model u_timer (.*);
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    function automatic logic [15:0] ad(input logic i, input logic [5:0] o);
        return {1'b0, i, 8'h00, o};
    endfunction : ad
    task automatic wr(input logic [15:0] a, input logic [31:0] d,
        input logic [1:0] er);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa || pw)
        begin
            @(negedge aclk);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            @(posedge aclk);
            if (!pa) s_axi_awvalid <= 1'b0;
            if (!pw) s_axi_wvalid <= 1'b0;
        end
        do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
        `CHK(s_axi_bresp, er)
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [31:0] e,
        input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
        `CHK(s_axi_rdata, e)
        `CHK(s_axi_rresp, er)
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic pulse(input logic [5:0] w);
        @(posedge aclk);
        fire <= 1'b1;
        which <= w;
        @(posedge aclk);
        fire <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask : pulse
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (5000) @(posedge aclk);
        fail_count++;
        close_out();
    end
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, fire} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, which} = '0;
        s_axi_wstrb = 4'hf;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (regs[k]) rd(ad(k % 2, regs[k]), 32'h0, OK);
        rd(ad(1'b0, dcic_pkg::OFF_CONTROL), 32'h0, OK);
        wr(16'h0030, 32'h1, DE);
        rd(16'h0040, 32'h0, DE);
        wr(ad(1'b0, dcic_pkg::OFF_HOLDING), 32'h155, OK);
        rd(ad(1'b0, dcic_pkg::OFF_OUTPUT), 32'h155, OK);
        rd(ad(1'b0, dcic_pkg::OFF_STATUS), 32'h0, OK);
        wr(ad(1'b0, dcic_pkg::OFF_MODE), 32'h10, OK);
        wr(ad(1'b0, dcic_pkg::OFF_HOLDING), 32'habcd12ff, OK);
        rd(ad(1'b0, dcic_pkg::OFF_HOLDING), 32'h3fc, OK);
        wr(ad(1'b0, dcic_pkg::OFF_MODE), 32'h0, OK);
        wr(ad(1'b0, dcic_pkg::OFF_HOLDING), 32'hfffffe01, OK);
        rd(ad(1'b0, dcic_pkg::OFF_HOLDING), 32'h201, OK);
        wr(ad(1'b0, dcic_pkg::OFF_IRQ_ENABLE), 32'h0, OK);
        rd(ad(1'b0, dcic_pkg::OFF_IRQ_MASK), 32'h0, OK);
        wr(ad(1'b0, dcic_pkg::OFF_IRQ_ENABLE), 32'h1, OK);
        wr(ad(1'b0, dcic_pkg::OFF_IRQ_DISABLE), 32'h0, OK);
        rd(ad(1'b0, dcic_pkg::OFF_IRQ_MASK), 32'h1, OK);
        @(negedge aclk);
        `CHK(conv_irq, 1'b0)
        last = 10'h201;
        for (int s = 6; s < 8; s++)
        begin
            wr(ad(1'b0, dcic_pkg::OFF_MODE), 32'(s * 2 + 1), OK);
            wr(ad(1'b0, dcic_pkg::OFF_HOLDING), 32'h0aa, OK);
            pulse(6'h3f);
            rd(ad(1'b0, dcic_pkg::OFF_OUTPUT), 32'(last), OK);
        end
        for (int s = 0; s < 6; s++)
        begin
            wr(ad(1'b0, dcic_pkg::OFF_MODE), 32'(s * 2 + 1), OK);
            wr(ad(1'b0, dcic_pkg::OFF_HOLDING), 32'(s + 10'h100), OK);
            rd(ad(1'b0, dcic_pkg::OFF_STATUS), 32'h0, OK);
            @(negedge aclk);
            `CHK(conv_irq, 1'b0)
            pulse(~(6'h01 << s));
            rd(ad(1'b0, dcic_pkg::OFF_OUTPUT), 32'(last), OK);
            pulse(6'h01 << s);
            last = 10'(s + 10'h100);
            rd(ad(1'b0, dcic_pkg::OFF_OUTPUT), 32'(last), OK);
            rd(ad(1'b0, dcic_pkg::OFF_STATUS), 32'h1, OK);
            @(negedge aclk);
            `CHK(conv_irq, 1'b1)
        end
        wr(ad(1'b0, dcic_pkg::OFF_MODE), 32'h0, OK);
        rd(ad(1'b0, dcic_pkg::OFF_STATUS), 32'h0, OK);
        wr(ad(1'b0, dcic_pkg::OFF_MODE), 32'h1, OK);
        rd(ad(1'b0, dcic_pkg::OFF_STATUS), 32'h1, OK);
        wr(ad(1'b0, dcic_pkg::OFF_IRQ_DISABLE), 32'h1, OK);
        rd(ad(1'b0, dcic_pkg::OFF_IRQ_MASK), 32'h0, OK);
        @(negedge aclk);
        `CHK(conv_irq, 1'b0)
        wr(ad(1'b1, dcic_pkg::OFF_HOLDING), 32'h3a5, OK);
        @(negedge aclk);
        `CHK(conv_out_data, {10'h3a5, last})
        wr(ad(1'b0, dcic_pkg::OFF_IRQ_ENABLE), 32'h1, OK);
        wr(ad(1'b0, dcic_pkg::OFF_CONTROL), 32'h0, OK);
        rd(ad(1'b0, dcic_pkg::OFF_MODE), 32'h1, OK);
        wr(ad(1'b0, dcic_pkg::OFF_CONTROL), 32'h1, OK);
        foreach (regs[k]) rd(ad(1'b0, regs[k]), 32'h0, OK);
        `CHK(conv_out_data, {10'h3a5, 10'h000})
        // instance 1 copied once above, so its sticky copy event stands
        wr(ad(1'b1, dcic_pkg::OFF_EVT_ENABLE), 32'h1, OK);
        rd(ad(1'b1, dcic_pkg::OFF_EVT_STATUS), 32'h1, OK);
        @(negedge aclk);
        `CHK(conv_irq, 1'b1)
        wr(ad(1'b1, dcic_pkg::OFF_EVT_CLEAR), 32'h1, OK);
        rd(ad(1'b1, dcic_pkg::OFF_EVT_STATUS), 32'h0, OK);
        @(negedge aclk);
        `CHK(conv_irq, 1'b0)
        close_out();
    end
endmodule : dac_control_interface_test
